// [io_image_params.svh]
`ifndef IO_IMAGE_PARAMS_SVH
`define IO_IMAGE_PARAMS_SVH
// Register byte addresses
`define ADDR_OUT_WORD 8'h00
`define ADDR_IN_WORD 8'h04
`define ADDR_DEV_DIAG 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_CTRL 8'h14
`define ADDR_DIAG_INDEX 8'h18
`define ADDR_DIAG_DATA 8'h1C
// Control fields and reset values
`define CTRL_OUT_EN 0
`define CTRL_TX_EN 1
`define CTRL_RESET 2'h3
// Interrupt status fields
`define IRQ_DIAG_CHANGE 0
`define IRQ_TX_DONE 1
`define IRQ_OUT_UPDATE 2
// Diagnostic block layout
`define DIAG_LEN 13
`define DIAG_ID_HI 4
`define DIAG_ID_LO 5
`define DIAG_HDR_BYTE 6
`define DIAG_DEV_BYTE 7
`define DIAG_HEADER 8'h07
// Nibble positions of groups one to four in a process word
`define GROUP1_LSB 8
`define GROUP2_LSB 12
`define GROUP3_LSB 0
`define GROUP4_LSB 4
`endif

// [io_image_pkg.sv]
`default_nettype none
package io_image_pkg;
  // One byte per entry, entry N is block byte N
  typedef logic [12:0][7:0] diag_block_t;
  // Telegram sender states
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage
`default_nettype wire

// [diag_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface diag_if;
  logic [2:0] dev_diag; // Live device diagnostic bits
  logic [31:0] station_status; // Bytes 0 to 3 from the bus engine
  io_image_pkg::diag_block_t block; // Composed block
  modport builder (input dev_diag, input station_status, output block);
  modport user (input block);
endinterface
`default_nettype wire

// [diag_block_builder.sv]
`timescale 1ns/1ns
`default_nettype none
`include "io_image_params.svh"
module diag_block_builder #(
  parameter logic [15:0] ID_CODE = 16'h5A3C // Arbitrary value
) (
  diag_if.builder diag
);
  import io_image_pkg::*;
  // ****************************************
  // Block composition, purely combinational
  // ****************************************
  always_comb begin
    diag.block = '0; // Reserved bytes 8 to 12 stay zero
    for (int i = 0; i < 4; i++) begin
      diag.block[i] = diag.station_status[8 * (3 - i) +: 8];
    end
    diag.block[`DIAG_ID_HI] = ID_CODE[15:8];
    diag.block[`DIAG_ID_LO] = ID_CODE[7:0];
    diag.block[`DIAG_HDR_BYTE] = `DIAG_HEADER;
    diag.block[`DIAG_DEV_BYTE] = {5'h00, diag.dev_diag};
  end
endmodule // diag_block_builder
`default_nettype wire

// [diag_telegram_sender.sv]
`timescale 1ns/1ns
`default_nettype none
`include "io_image_params.svh"
module diag_telegram_sender (
  input wire logic clock_in,
  input wire logic reset_n_in,
  diag_if.user diag,
  input wire logic start_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic [3:0] tx_index_out,
  output logic tx_last_out,
  output logic busy_out,
  output logic done_out
);
  import io_image_pkg::*;
  diag_block_t snap_reg; // Frozen copy so a telegram is self consistent
  io_image_pkg::tx_state_t state_reg; // Sender state
  logic [3:0] idx_reg; // Byte being offered
  logic last_beat; // Offering the final byte
  assign last_beat = (idx_reg == 4'(`DIAG_LEN - 1));
  // ****************************************
  // Byte sequencer, one telegram per start
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg <= TX_IDLE;
      snap_reg <= '0;
      idx_reg <= 4'h0;
      tx_data_out <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_reg)
        TX_IDLE: begin
          if (start_in) begin
            snap_reg <= diag.block;
            idx_reg <= 4'h0;
            tx_data_out <= diag.block[0];
            state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_ready_in && last_beat) begin
            state_reg <= TX_IDLE;
            done_out <= 1'b1;
          end else if (tx_ready_in) begin
            idx_reg <= idx_reg + 4'h1;
            tx_data_out <= snap_reg[idx_reg + 4'h1];
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end
  assign busy_out = (state_reg == TX_SEND);
  assign tx_valid_out = busy_out;
  assign tx_index_out = idx_reg;
  assign tx_last_out = busy_out && last_beat;
endmodule // diag_telegram_sender
`default_nettype wire

// [fieldbus_io_image_and_diag.sv]
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "io_image_params.svh"
module fieldbus_io_image_and_diag #(
  parameter logic [15:0] ID_CODE = 16'h5A3C // Arbitrary value
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Software register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  // Process data from and to the bus engine
  input wire logic pd_out_write_in,
  input wire logic [7:0] pd_out_byte0_in,
  input wire logic [7:0] pd_out_byte1_in,
  output logic [7:0] pd_in_byte0_out,
  output logic [7:0] pd_in_byte1_out,
  // Diagnostic block read by the bus engine
  input wire logic [3:0] diag_read_index_in,
  output logic [7:0] diag_read_data_out,
  input wire logic [31:0] station_status_in,
  // Diagnostic telegram stream
  input wire logic diag_tx_ready_in,
  output logic diag_tx_valid_out,
  output logic [7:0] diag_tx_data_out,
  output logic [3:0] diag_tx_index_out,
  output logic diag_tx_last_out,
  // Field side
  input wire logic [15:0] digital_in,
  output logic [15:0] digital_out,
  input wire logic [3:0] output_short_in,
  input wire logic [3:0] sensor_overload_in,
  input wire logic sensor_low_in,
  input wire logic [1:0] actuator_low_in,
  // Indicators
  output logic [15:0] output_led_out,
  output logic [15:0] input_led_out,
  output logic [3:0] output_error_led_out,
  output logic [3:0] input_error_led_out,
  output logic general_diag_indicator_out,
  output logic sensor_power_indicator_out,
  output logic [1:0] actuator_supply_led_out
);
  import io_image_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] out_word_reg; // Output image as written by the master
  logic [15:0] out_word_next; // Next output image
  logic [15:0] in_word_reg; // Input image in bus byte order
  logic [15:0] in_word_next; // Input image before the register
  logic [15:0] out_field_next; // Output image in group order
  logic [2:0] dev_diag_reg; // Device diagnostic bits, registered
  logic [2:0] dev_diag_next; // Device diagnostic bits from the fault inputs
  logic diag_change; // Any device bit differs from its last value
  logic tx_pending_reg; // A telegram is owed to the master
  logic tx_start; // Launch a telegram this cycle
  logic tx_busy; // Sender is streaming
  logic tx_done; // Sender finished a telegram
  logic [1:0] ctrl_reg; // Output enable and telegram enable
  logic [2:0] irq_status_reg; // Sticky event bits
  logic [2:0] irq_mask_reg; // Enables for the sticky bits
  logic [2:0] irq_events; // Events raised this cycle
  logic [2:0] irq_clear; // Bits written with one to the status
  logic [3:0] diag_index_reg; // Software window into the block
  logic [31:0] rdata_next; // Read mux result
  logic wr_status; // Write to the status register
  logic [7:0] sw_diag_byte; // Block byte picked by software
  logic [7:0] bus_diag_byte; // Block byte picked by the bus engine

  // Shared view of the diagnostic block
  diag_if u_diag ();

  // ****************************************
  // Group routing
  // ****************************************
  // Field pins are numbered group by group; the process word puts groups
  // two and one in byte 0 and four and three in byte 1.
  function automatic int unsigned group_lsb(input int unsigned g);
    case (g)
      0: group_lsb = `GROUP1_LSB;
      1: group_lsb = `GROUP2_LSB;
      2: group_lsb = `GROUP3_LSB;
      default: group_lsb = `GROUP4_LSB;
    endcase
  endfunction

  // Nibble LSB is channel one, MSB channel four, in both directions
  for (genvar g = 0; g < 4; g++) begin : g_group
    for (genvar c = 0; c < 4; c++) begin : g_chan
      // Output channel c of group g takes its word bit
      assign out_field_next[4 * g + c] = out_word_reg[group_lsb(g) + c];
      // Input channel c of group g lands at its word bit
      assign in_word_next[group_lsb(g) + c] = digital_in[4 * g + c];
    end
  end

  // ****************************************
  // Output image
  // ****************************************
  // Byte 0 carries word bits 15..8, byte 1 bits 7..0
  always_comb begin
    out_word_next = out_word_reg;
    if (pd_out_write_in) begin
      // Master delivers a fresh image
      out_word_next = {pd_out_byte0_in, pd_out_byte1_in};
    end
  end

  // Output image register
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      out_word_reg <= 16'h0000;
    end else begin
      out_word_reg <= out_word_next;
    end
  end

  // Field outputs; clearing the enable forces every actuator off
  // without losing the master's image
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      digital_out <= 16'h0000;
    end else if (ctrl_reg[`CTRL_OUT_EN]) begin
      digital_out <= out_field_next;
    end else begin
      digital_out <= 16'h0000;
    end
  end

  // Channel LEDs mirror the driven outputs bit for bit
  assign output_led_out = digital_out;

  // ****************************************
  // Input image
  // ****************************************
  // Inputs are synchronous, so one register stage is enough
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      in_word_reg <= 16'h0000;
      input_led_out <= 16'h0000;
    end else begin
      in_word_reg <= in_word_next;
      input_led_out <= digital_in;
    end
  end

  // Same byte order as the output word
  assign pd_in_byte0_out = in_word_reg[15:8];
  assign pd_in_byte1_out = in_word_reg[7:0];

  // ****************************************
  // Device diagnostics
  // ****************************************
  // Bits follow the fault levels, with no latching
  always_comb begin
    dev_diag_next = 3'h0;
    dev_diag_next[0] = |output_short_in;
    dev_diag_next[1] = |sensor_overload_in;
    dev_diag_next[2] = sensor_low_in;
  end

  // Actuator supply faults are deliberately absent from the bits
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      dev_diag_reg <= 3'h0;
    end else begin
      dev_diag_reg <= dev_diag_next;
    end
  end

  // Setting or clearing any bit counts as an event
  assign diag_change = (dev_diag_next != dev_diag_reg);

  // ****************************************
  // Indicators
  // ****************************************
  // Registered with the diagnostic bits so LEDs and bits agree
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      output_error_led_out <= 4'h0;
      input_error_led_out <= 4'h0;
      sensor_power_indicator_out <= 1'b0;
      actuator_supply_led_out <= 2'h0;
    end else begin
      // Only the affected group shows red
      output_error_led_out <= output_short_in;
      // One error LED per sensor supply
      input_error_led_out <= sensor_overload_in;
      // Sensor power LED goes dark on low voltage
      sensor_power_indicator_out <= !sensor_low_in;
      // Actuator LEDs only, no diagnostic effect
      actuator_supply_led_out <= ~actuator_low_in;
    end
  end

  // Red while any device bit is set, normal once all clear
  assign general_diag_indicator_out = |dev_diag_reg;

  // ****************************************
  // Diagnostic block and telegram
  // ****************************************
  assign u_diag.dev_diag = dev_diag_reg;
  assign u_diag.station_status = station_status_in;

  // Builds the 13-byte block from live state
  diag_block_builder #(
    .ID_CODE(ID_CODE)
  ) u_builder (
    .diag(u_diag)
  );

  // Streams one snapshot of the block per start
  diag_telegram_sender u_sender (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .diag(u_diag),
    .start_in(tx_start),
    .tx_ready_in(diag_tx_ready_in),
    .tx_valid_out(diag_tx_valid_out),
    .tx_data_out(diag_tx_data_out),
    .tx_index_out(diag_tx_index_out),
    .tx_last_out(diag_tx_last_out),
    .busy_out(tx_busy),
    .done_out(tx_done)
  );

  // Events during a telegram fold into one follow-up telegram, which
  // then carries the newest state; a new event beats the launch clear
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      tx_pending_reg <= 1'b0;
    end else if (diag_change) begin
      tx_pending_reg <= 1'b1;
    end else if (tx_start) begin
      tx_pending_reg <= 1'b0;
    end
  end

  // Launch only when idle and allowed by software
  assign tx_start = tx_pending_reg && !tx_busy && ctrl_reg[`CTRL_TX_EN];

  // Block bytes for the two readers; out of range reads as zero
  always_comb begin
    sw_diag_byte = 8'h00;
    bus_diag_byte = 8'h00;
    if (diag_index_reg < 4'(`DIAG_LEN)) begin
      sw_diag_byte = u_diag.block[diag_index_reg];
    end
    if (diag_read_index_in < 4'(`DIAG_LEN)) begin
      bus_diag_byte = u_diag.block[diag_read_index_in];
    end
  end

  // Bus engine read: data one cycle after the index, any time
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      diag_read_data_out <= 8'h00;
    end else begin
      diag_read_data_out <= bus_diag_byte;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Control, block index and interrupt mask, plain read/write
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= `CTRL_RESET;
      diag_index_reg <= 4'h0;
      irq_mask_reg <= 3'h0;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        `ADDR_CTRL: ctrl_reg <= reg_wdata_in[1:0];
        `ADDR_DIAG_INDEX: diag_index_reg <= reg_wdata_in[3:0];
        `ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irq_events = 3'h0;
    irq_events[`IRQ_DIAG_CHANGE] = diag_change;
    irq_events[`IRQ_TX_DONE] = tx_done;
    irq_events[`IRQ_OUT_UPDATE] = pd_out_write_in;
  end

  assign wr_status = reg_write_in && (reg_addr_in == `ADDR_IRQ_STATUS);
  assign irq_clear = wr_status ? reg_wdata_in[2:0] : 3'h0;

  // Write one to clear; an event in the same cycle wins
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      irq_status_reg <= 3'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
    end
  end

  // Level output, high while an unmasked bit is set
  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // ****************************************
  // Register read
  // ****************************************
  // Unmapped addresses read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr_in)
      `ADDR_OUT_WORD: rdata_next = {16'h0000, out_word_reg};
      `ADDR_IN_WORD: rdata_next = {16'h0000, in_word_reg};
      `ADDR_DEV_DIAG: rdata_next = {29'h0000_0000, dev_diag_reg};
      `ADDR_IRQ_STATUS: rdata_next = {29'h0000_0000, irq_status_reg};
      `ADDR_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
      `ADDR_CTRL: rdata_next = {30'h0000_0000, ctrl_reg};
      `ADDR_DIAG_INDEX: rdata_next = {28'h000_0000, diag_index_reg};
      `ADDR_DIAG_DATA: rdata_next = {24'h00_0000, sw_diag_byte};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_read_in) begin
      reg_rdata_out <= rdata_next;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end
endmodule // fieldbus_io_image_and_diag
`default_nettype wire

// [fieldbus_io_image_and_diag_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker for the io image and diagnostic block
// ********
module io_image_checker (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [15:0] digital_in,
  input wire logic [15:0] input_led_out,
  input wire logic [7:0] pd_in_byte0_out,
  input wire logic [7:0] pd_in_byte1_out,
  input wire logic [3:0] output_short_in,
  input wire logic [3:0] sensor_overload_in,
  input wire logic sensor_low_in,
  input wire logic [1:0] actuator_low_in,
  input wire logic [3:0] output_error_led_out,
  input wire logic [3:0] input_error_led_out,
  input wire logic general_diag_indicator_out,
  input wire logic sensor_power_indicator_out,
  input wire logic [1:0] actuator_supply_led_out,
  input wire logic diag_tx_ready_in,
  input wire logic diag_tx_valid_out,
  input wire logic [7:0] diag_tx_data_out,
  input wire logic [3:0] diag_tx_index_out,
  input wire logic diag_tx_last_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  // Indicators lag their cause by one edge; guarded so reset-time inputs never count
  AST_GEN_LED: assert property ($past(reset_n_in) |->
    general_diag_indicator_out == |{$past(output_short_in), $past(sensor_overload_in),
    $past(sensor_low_in)}) else $error("general indicator wrong");
  AST_OUT_ERR: assert property ($past(reset_n_in) |->
    output_error_led_out == $past(output_short_in)) else $error("output error led wrong");
  AST_IN_ERR: assert property ($past(reset_n_in) |->
    input_error_led_out == $past(sensor_overload_in)) else $error("input error led wrong");
  AST_SNS_PWR: assert property ($past(reset_n_in) |->
    sensor_power_indicator_out == !$past(sensor_low_in)) else $error("sensor power led wrong");
  AST_ACT_LED: assert property ($past(reset_n_in) |->
    actuator_supply_led_out == ~$past(actuator_low_in)) else $error("actuator led wrong");
  // Pin nibbles 1,0 land in the high byte, 3,2 in the low byte
  AST_IN_IMG: assert property ($past(reset_n_in) |->
    {pd_in_byte0_out, pd_in_byte1_out} == {$past(digital_in[7:0]), $past(digital_in[15:8])}
    && input_led_out == $past(digital_in)) else $error("input image wrong");
  AST_TX_HOLD: assert property (diag_tx_valid_out && !diag_tx_ready_in |=>
    diag_tx_valid_out && $stable(diag_tx_data_out) && $stable(diag_tx_index_out))
    else $error("telegram byte not held");
  AST_TX_STEP: assert property (diag_tx_valid_out && diag_tx_ready_in && !diag_tx_last_out
    |=> diag_tx_valid_out && diag_tx_index_out == $past(diag_tx_index_out) + 4'h1)
    else $error("telegram index skipped");
  AST_TX_LAST: assert property (diag_tx_last_out |->
    diag_tx_valid_out && diag_tx_index_out == 4'hC) else $error("last flag misplaced");
  AST_TX_HDR: assert property (diag_tx_valid_out && diag_tx_index_out == 4'h6 |->
    diag_tx_data_out == 8'h07) else $error("header byte wrong");
endmodule // io_image_checker

bind fieldbus_io_image_and_diag io_image_checker i_chk (.clock_in(clock_in),
  .reset_n_in(reset_n_in), .digital_in(digital_in), .input_led_out(input_led_out),
  .pd_in_byte0_out(pd_in_byte0_out), .pd_in_byte1_out(pd_in_byte1_out),
  .output_short_in(output_short_in), .sensor_overload_in(sensor_overload_in),
  .sensor_low_in(sensor_low_in), .actuator_low_in(actuator_low_in),
  .output_error_led_out(output_error_led_out), .input_error_led_out(input_error_led_out),
  .general_diag_indicator_out(general_diag_indicator_out),
  .sensor_power_indicator_out(sensor_power_indicator_out),
  .actuator_supply_led_out(actuator_supply_led_out), .diag_tx_ready_in(diag_tx_ready_in),
  .diag_tx_valid_out(diag_tx_valid_out), .diag_tx_data_out(diag_tx_data_out),
  .diag_tx_index_out(diag_tx_index_out), .diag_tx_last_out(diag_tx_last_out));
`default_nettype wire

// [diag_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// Bus master side that takes the diagnostic telegram
// ********
module diag_master_model (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic slow_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic [3:0] index_in,
  input wire logic last_in,
  output logic ready_out
);
  logic [7:0] rx_bytes [13]; // Latest telegram by byte number
  int n_tel; // Whole telegrams taken
  // A slow master accepts only every other cycle, to stretch telegrams
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ready_out <= 1'b0;
      n_tel <= 0;
    end else begin
      ready_out <= slow_in ? !ready_out : 1'b1;
      if (valid_in && ready_out) begin
        rx_bytes[index_in] <= data_in;
        if (last_in) begin
          n_tel <= n_tel + 1;
        end
      end
    end
  end
endmodule // diag_master_model
`default_nettype wire

// [fieldbus_io_image_and_diag_test.sv]
`timescale 1ns/1ns
`default_nettype none
module fieldbus_io_image_and_diag_test;
  localparam logic [15:0] TB_ID = 16'hC35A; // Arbitrary value
  logic clock_in = 1'b0, reset_n_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic pd_out_write_in = 1'b0, sensor_low_in = 1'b0, slow = 1'b0, irq_out;
  logic [7:0] reg_addr_in = 8'h00, pd_out_byte0_in = 8'h00, pd_out_byte1_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, station_status_in = 32'h8124_0310, reg_rdata_out;
  logic [3:0] diag_read_index_in = 4'h0, output_short_in = 4'h0, sensor_overload_in = 4'h0;
  logic [1:0] actuator_low_in = 2'h0, act_led;
  logic [15:0] digital_in = 16'h0, digital_out, output_led_out, input_led_out;
  logic [7:0] pd_in0, pd_in1, rd_data, tx_data;
  logic [3:0] tx_index, out_err, in_err;
  logic tx_ready, tx_valid, tx_last, gen_led, sns_led;
  int mismatches = 0, n_checks = 0, cycles = 0;
  fieldbus_io_image_and_diag #(.ID_CODE(TB_ID)) i_dut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out), .pd_out_write_in(pd_out_write_in), .pd_out_byte0_in(pd_out_byte0_in),
    .pd_out_byte1_in(pd_out_byte1_in), .pd_in_byte0_out(pd_in0), .pd_in_byte1_out(pd_in1),
    .diag_read_index_in(diag_read_index_in), .diag_read_data_out(rd_data),
    .station_status_in(station_status_in), .diag_tx_ready_in(tx_ready),
    .diag_tx_valid_out(tx_valid), .diag_tx_data_out(tx_data), .diag_tx_index_out(tx_index),
    .diag_tx_last_out(tx_last), .digital_in(digital_in), .digital_out(digital_out),
    .output_short_in(output_short_in), .sensor_overload_in(sensor_overload_in),
    .sensor_low_in(sensor_low_in), .actuator_low_in(actuator_low_in),
    .output_led_out(output_led_out), .input_led_out(input_led_out),
    .output_error_led_out(out_err), .input_error_led_out(in_err),
    .general_diag_indicator_out(gen_led), .sensor_power_indicator_out(sns_led),
    .actuator_supply_led_out(act_led));
  diag_master_model i_master (.clock_in(clock_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .valid_in(tx_valid), .data_in(tx_data), .index_in(tx_index), .last_in(tx_last),
    .ready_out(tx_ready));
  // ********
  // Clock, hang guard and shared tasks
  // ********
  always #2 clock_in = ~clock_in;
  // Whole run needs under two thousand cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leaves time just after an edge, where outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // Strobe tasks end one idle cycle later, so no strobe is set twice in a step
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    tick(1);
    reg_write_in <= 1'b0;
    tick(1);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    tick(1);
    reg_read_in <= 1'b0;
    v = reg_rdata_out;
    tick(1);
  endtask
  task automatic pd_wr(input logic [15:0] w);
    pd_out_byte0_in <= w[15:8];
    pd_out_byte1_in <= w[7:0];
    pd_out_write_in <= 1'b1;
    tick(1);
    pd_out_write_in <= 1'b0;
    tick(1);
  endtask
  // Waits for telegram n, then compares every byte against the expected block
  task automatic expect_tel(input int n, input logic [7:0] dev);
    logic [7:0] e [13];
    int k;
    k = 0;
    while (i_master.n_tel != n && k < 400) begin
      tick(1);
      k++;
    end
    e = '{default: 8'h00};
    {e[0], e[1], e[2], e[3]} = station_status_in;
    {e[4], e[5]} = TB_ID;
    e[6] = 8'h07;
    e[7] = dev;
    for (int i = 0; i < 13; i++) begin
      chk("telegram byte", {24'h0, e[i]}, {24'h0, i_master.rx_bytes[i]});
    end
    tick(40);
    chk("telegram count", n, i_master.n_tel);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs_and_irq();
    logic [31:0] v;
    reg_rd(8'h14, v);
    chk("ctrl reset", 32'h3, v);
    reg_wr(8'h24, 32'hFFFF_FFFF);
    reg_rd(8'h24, v);
    chk("unmapped read", 32'h0, v);
    reg_wr(8'h18, 32'h4);
    reg_rd(8'h1C, v);
    chk("block id high", {24'h0, TB_ID[15:8]}, v);
    pd_wr(16'h0000);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    reg_wr(8'h10, 32'h4);
    chk("irq raised", 32'h1, {31'h0, irq_out});
    reg_wr(8'h0C, 32'h4);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
  endtask
  // Walks one channel through every bit, both directions, checking nibble and channel order
  task automatic t_channels();
    logic [15:0] pin;
    logic [15:0] w;
    for (int i = 0; i < 16; i++) begin
      pin = 16'h1 << i;
      w = {pin[7:0], pin[15:8]};
      digital_in <= pin;
      pd_wr(w);
      tick(1);
      chk("input word", {16'h0, w}, {16'h0, pd_in0, pd_in1});
      chk("input leds", {16'h0, pin}, {16'h0, input_led_out});
      chk("output pins", {16'h0, pin}, {16'h0, digital_out});
      chk("output leds", {16'h0, pin}, {16'h0, output_led_out});
    end
    reg_wr(8'h14, 32'h2);
    tick(2);
    chk("outputs disabled", 32'h0, {16'h0, digital_out});
    reg_wr(8'h14, 32'h3);
  endtask
  task automatic t_diag();
    logic [31:0] v;
    output_short_in <= 4'h4;
    diag_read_index_in <= 4'h7;
    tick(2);
    chk("output error led", 32'h4, {28'h0, out_err});
    chk("general led", 32'h1, {31'h0, gen_led});
    chk("live diag byte", 32'h1, {24'h0, rd_data});
    expect_tel(1, 8'h01);
    reg_rd(8'h0C, v);
    chk("irq status", 32'h7, v);
    slow <= 1'b1;
    sensor_overload_in <= 4'h1;
    tick(4);
    sensor_low_in <= 1'b1;
    tick(2);
    chk("input error led", 32'h1, {28'h0, in_err});
    chk("sensor power led", 32'h0, {31'h0, sns_led});
    expect_tel(3, 8'h07);
    slow <= 1'b0;
    actuator_low_in <= 2'h2;
    tick(2);
    chk("actuator leds", 32'h1, {30'h0, act_led});
    expect_tel(3, 8'h07);
    reg_rd(8'h08, v);
    chk("device bits", 32'h7, v);
    reg_wr(8'h14, 32'h1);
    output_short_in <= 4'h0;
    sensor_overload_in <= 4'h0;
    sensor_low_in <= 1'b0;
    tick(20);
    chk("telegram held", 32'h3, i_master.n_tel);
    reg_wr(8'h14, 32'h3);
    expect_tel(4, 8'h00);
    chk("general led clear", 32'h0, {31'h0, gen_led});
    chk("live diag clear", 32'h0, {24'h0, rd_data});
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (6) @(posedge clock_in);
    reset_n_in <= 1'b1;
    tick(1);
    t_regs_and_irq();
    t_channels();
    t_diag();
    complete_run();
  end
endmodule // fieldbus_io_image_and_diag_test
`default_nettype wire
